// file: hdl/agpt_pkg.sv
// Shared constants for the advanced general purpose timer.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
package agpt_pkg;
  // ==========================================
  // Variant selection
  localparam logic [1:0] VAR_ADV = 2'h0;
  localparam logic [1:0] VAR_WIDE = 2'h1;
  localparam logic [1:0] VAR_SMALL = 2'h2;
  localparam int NUM_CH = 4;
  localparam int NUM_CMP_ADV = 3;
  localparam int CNT_W_MAX = 32;
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFF_FFFF;
  localparam int PSC_W = 16;
  localparam int DT_W = 8;
  // ==========================================
  // Channel modes
  localparam logic [1:0] CH_OFF = 2'h0;
  localparam logic [1:0] CH_CAPTURE = 2'h1;
  localparam logic [1:0] CH_COMPARE = 2'h2;
  localparam logic [1:0] CH_PWM = 2'h3;
  // ==========================================
  // Trigger modes
  localparam logic [1:0] TRG_NONE = 2'h0;
  localparam logic [1:0] TRG_START = 2'h1;
  localparam logic [1:0] TRG_CLOCK = 2'h2;
  // ==========================================
  // Reset values
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [15:0] PSC_RST = 16'h0000;
  localparam logic [7:0] DT_RST = 8'h00;
  // Run state machine, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DONE = 4'b1000
  } agpt_state_e;
endpackage

// file: hdl/agpt_channel.sv
// One capture/compare channel with optional complementary output.
// Assumes cap_in is already synchronised and cnt is the live count.
module agpt_channel (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] cnt,
  input wire logic [31:0] ccr,
  input wire logic [1:0] mode,
  input wire logic pol,
  input wire logic cap_in,
  input wire logic cmp_en,
  input wire logic [7:0] dead_time,
  input wire logic force_off,
  input wire logic tick,
  output logic oc,
  output logic ocn,
  output logic [31:0] cap_val,
  output logic cc_evt
);
  logic ref_q, ref_d, cap_p_q, oc_q, oc_d, ocn_q, ocn_d, evt_q, evt_d;
  logic [7:0] dt_q, dt_d;
  logic [31:0] cap_q, cap_d;

  // ==========================================
  // Reference, capture and dead time
  // capture, compare, PWM per channel
  always_comb begin
    ref_d = ref_q;
    cap_d = cap_q;
    evt_d = 1'b0;
    dt_d = (dt_q != 8'h00) ? dt_q - 8'h01 : dt_q;
    case (mode)
      agpt_pkg::CH_CAPTURE: begin
        if (cap_in && !cap_p_q) begin
          cap_d = cnt;
          evt_d = 1'b1;
        end
      end
      agpt_pkg::CH_COMPARE: begin
        if (tick && cnt == ccr) begin
          ref_d = ~ref_q;
          evt_d = 1'b1;
        end
      end
      // 0 gives 0%, above reload 100%
      agpt_pkg::CH_PWM: begin
        ref_d = (cnt < ccr);
        evt_d = tick && (cnt == ccr);
      end
      default: ref_d = 1'b0;
    endcase
    // hold both low for dead time
    if (ref_d != ref_q) begin
      dt_d = dead_time;
    end
    oc_d = (ref_d ^ pol) && (dt_d == 8'h00);
    ocn_d = cmp_en && (!ref_d ^ pol) && (dt_d == 8'h00);
    if (force_off || mode == agpt_pkg::CH_OFF || mode == agpt_pkg::CH_CAPTURE) begin
      oc_d = 1'b0;
      ocn_d = 1'b0;
    end
  end

  // Registered so pins never glitch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 1'b0;
      cap_p_q <= 1'b0;
      oc_q <= 1'b0;
      ocn_q <= 1'b0;
      evt_q <= 1'b0;
      dt_q <= agpt_pkg::DT_RST;
      cap_q <= agpt_pkg::CNT_RST;
    end else begin
      ref_q <= ref_d;
      cap_p_q <= cap_in;
      oc_q <= oc_d;
      ocn_q <= ocn_d;
      evt_q <= evt_d;
      dt_q <= dt_d;
      cap_q <= cap_d;
    end
  end

  assign oc = oc_q;
  assign ocn = ocn_q;
  assign cap_val = cap_q;
  assign cc_evt = evt_q;

  a_no_overlap: assert property (@(posedge clock) disable iff (!rst_n) !(oc_q && ocn_q && !pol))
    else $error("Complementary outputs overlap");
endmodule

// file: hdl/agpt_timer.sv
// Multichannel timer core: prescaler, counter, four channels.
// Assumes control inputs are steady from software on this clock;
// pin inputs (channels, encoder) arrive asynchronous.
// What this block does
// - advanced 16-bit counter, wide variant 32-bit
// - prescaler divides by 1 to 65536
// - small variants count up, 16-bit reload
// - four channels: capture, compare, PWM, pulse
// - edge or center PWM, 0-100% duty
// - advanced: three complementary pairs with dead time
// - debug halt freezes counter, advanced outputs off
// - export and accept trigger events
// - wide variant quadrature encoder counting
// - own DMA requests on update, capture
// - small variants: one channel, one complement
// - small channel supports all channel modes
// - usable as plain periodic time base
module agpt_timer #(
  parameter logic [1:0] VARIANT = agpt_pkg::VAR_ADV
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cnt_en,
  input wire logic dir_down,
  input wire logic center_mode,
  input wire logic one_pulse,
  input wire logic encoder_mode,
  input wire logic [15:0] psc_div,
  input wire logic [31:0] arr,
  input wire logic [3:0][31:0] ccr,
  input wire logic [3:0][1:0] ch_mode,
  input wire logic [3:0] ch_pol,
  input wire logic [7:0] dead_time,
  input wire logic dbg_halt,
  input wire logic dbg_freeze_en,
  input wire logic [1:0] trig_mode,
  input wire logic trig_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] ch_in,
  output logic [31:0] cnt_val,
  output logic upd_evt,
  output logic trig_out,
  output logic counting,
  output logic [3:0] ch_out,
  output logic [2:0] ch_out_n,
  output logic [3:0][31:0] cap_val,
  output logic [3:0] cc_evt,
  output logic dma_req_upd,
  output logic [3:0] dma_req_cc
);
  // ==========================================
  // Variant properties
  // width set by variant
  localparam logic [31:0] CNT_MASK = (VARIANT == agpt_pkg::VAR_WIDE) ? agpt_pkg::MASK_32 : agpt_pkg::MASK_16;
  localparam bit IS_ADV = (VARIANT == agpt_pkg::VAR_ADV);
  localparam bit IS_SMALL = (VARIANT == agpt_pkg::VAR_SMALL);
  localparam bit HAS_ENC = (VARIANT == agpt_pkg::VAR_WIDE);

  // ==========================================
  // Pin synchronisers
  logic [3:0] ch_s1_q, ch_s2_q;
  logic enc_a1_q, enc_a2_q, enc_b1_q, enc_b2_q, enc_ap_q, enc_bp_q;

  // Two stages before any logic sees a pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch_s1_q <= 4'h0;
      ch_s2_q <= 4'h0;
      enc_a1_q <= 1'b0;
      enc_a2_q <= 1'b0;
      enc_b1_q <= 1'b0;
      enc_b2_q <= 1'b0;
      enc_ap_q <= 1'b0;
      enc_bp_q <= 1'b0;
    end else begin
      ch_s1_q <= ch_in;
      ch_s2_q <= ch_s1_q;
      enc_a1_q <= enc_a;
      enc_a2_q <= enc_a1_q;
      enc_b1_q <= enc_b;
      enc_b2_q <= enc_b1_q;
      enc_ap_q <= enc_a2_q;
      enc_bp_q <= enc_b2_q;
    end
  end

  // ==========================================
  // Run control
  agpt_pkg::agpt_state_e st_q, st_d;
  logic frozen, running, tick, psc_wrap, enc_step, enc_up, go_up, use_enc;
  logic [31:0] arr_m;
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] psc_q, psc_d;
  logic ctr_down_q, ctr_down_d, upd_q, upd_d;
  logic [3:0] cc_int;

  assign arr_m = arr & CNT_MASK;
  // freeze only while halted and enabled
  assign frozen = dbg_halt && dbg_freeze_en;
  assign running = (st_q == agpt_pkg::ST_RUN) && !frozen;
  assign use_enc = HAS_ENC && encoder_mode;

  // start on trigger from another timer
  always_comb begin
    st_d = st_q;
    case (st_q)
      agpt_pkg::ST_IDLE: begin
        if (cnt_en) begin
          st_d = (trig_mode == agpt_pkg::TRG_START) ? agpt_pkg::ST_WAIT : agpt_pkg::ST_RUN;
        end
      end
      agpt_pkg::ST_WAIT: begin
        if (!cnt_en) begin
          st_d = agpt_pkg::ST_IDLE;
        end else if (trig_in) begin
          st_d = agpt_pkg::ST_RUN;
        end
      end
      agpt_pkg::ST_RUN: begin
        if (!cnt_en) begin
          st_d = agpt_pkg::ST_IDLE;
        end else if (one_pulse && upd_d) begin
          st_d = agpt_pkg::ST_DONE; // One-pulse stops at the wrap
        end
      end
      agpt_pkg::ST_DONE: begin
        if (!cnt_en) begin
          st_d = agpt_pkg::ST_IDLE;
        end
      end
      default: st_d = agpt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= agpt_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Prescaler and count tick
  // psc_div holds ratio minus one
  assign psc_wrap = (psc_q == psc_div);
  assign enc_step = (enc_a2_q ^ enc_ap_q) || (enc_b2_q ^ enc_bp_q);
  assign enc_up = enc_a2_q ^ enc_bp_q;

  always_comb begin
    if (use_enc) begin
      tick = running && enc_step;
    end else if (trig_mode == agpt_pkg::TRG_CLOCK) begin
      tick = running && trig_in;
    end else begin
      tick = running && psc_wrap;
    end
  end

  always_comb begin
    psc_d = psc_q;
    if (running) begin
      psc_d = psc_wrap ? agpt_pkg::PSC_RST : psc_q + 16'h0001;
    end
  end

  // ==========================================
  // Counter
  // small variants never count down
  always_comb begin
    if (use_enc) begin
      go_up = enc_up;
    end else if (IS_SMALL) begin
      go_up = 1'b1;
    end else if (center_mode) begin
      go_up = !ctr_down_q;
    end else begin
      go_up = !dir_down;
    end
  end

  // wrap against reload, update on wrap
  always_comb begin
    cnt_d = cnt_q;
    ctr_down_d = ctr_down_q;
    upd_d = 1'b0;
    if (tick) begin
      if (go_up) begin
        if (cnt_q >= arr_m) begin
          upd_d = 1'b1;
          if (center_mode && !use_enc && !IS_SMALL) begin
            // center mode turns round at top
            cnt_d = (arr_m - 32'h0000_0001) & CNT_MASK;
            ctr_down_d = 1'b1;
          end else begin
            cnt_d = agpt_pkg::CNT_RST;
          end
        end else begin
          cnt_d = (cnt_q + 32'h0000_0001) & CNT_MASK;
        end
      end else begin
        if (cnt_q == 32'h0000_0000) begin
          upd_d = 1'b1;
          if (center_mode && !use_enc) begin
            cnt_d = 32'h0000_0001 & CNT_MASK;
            ctr_down_d = 1'b0;
          end else begin
            cnt_d = arr_m;
          end
        end else begin
          cnt_d = (cnt_q - 32'h0000_0001) & CNT_MASK;
        end
      end
    end
  end

  // frozen timer keeps count and prescaler
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= agpt_pkg::CNT_RST;
      psc_q <= agpt_pkg::PSC_RST;
      ctr_down_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      psc_q <= psc_d;
      ctr_down_q <= ctr_down_d;
      upd_q <= upd_d;
    end
  end

  // ==========================================
  // Channels
  // small variants keep only channel 0
  genvar gi;
  generate
    for (gi = 0; gi < agpt_pkg::NUM_CH; gi++) begin : g_ch
      localparam bit CH_LIVE = !IS_SMALL || (gi == 0);
      localparam bit CH_CMP = IS_ADV ? (gi < agpt_pkg::NUM_CMP_ADV) : (IS_SMALL && gi == 0);
      logic oc_w, ocn_w, evt_w;
      logic [31:0] cap_w;
      agpt_channel u_ch (
        .clock(clock),
        .rst_n(rst_n),
        .cnt(cnt_q),
        .ccr(ccr[gi] & CNT_MASK),
        .mode(CH_LIVE ? ch_mode[gi] : agpt_pkg::CH_OFF),
        .pol(ch_pol[gi]),
        .cap_in(ch_s2_q[gi]),
        .cmp_en(CH_CMP),
        .dead_time(dead_time),
        .force_off(IS_ADV && dbg_halt), // advanced variant only switches off in halt
        .tick(tick),
        .oc(oc_w),
        .ocn(ocn_w),
        .cap_val(cap_w),
        .cc_evt(evt_w)
      );
      assign ch_out[gi] = oc_w;
      assign cap_val[gi] = cap_w;
      assign cc_int[gi] = evt_w;
      if (gi < 3) begin : g_n
        assign ch_out_n[gi] = ocn_w;
      end
    end
  endgenerate

  // ==========================================
  // Event outputs
  // per-instance DMA requests
  // update alone gives a time base
  assign cnt_val = cnt_q;
  assign upd_evt = upd_q;
  assign trig_out = upd_q; // update exported as trigger
  assign dma_req_upd = upd_q;
  assign cc_evt = cc_int;
  assign dma_req_cc = cc_int;
  assign counting = running;

  // ==========================================
  // Checks
  a_psc_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    running && psc_wrap |=> psc_q == 16'h0000)
    else $error("Prescaler did not restart");
  a_psc_step: assert property (@(posedge clock) disable iff (!rst_n)
    running && !psc_wrap |=> psc_q == $past(psc_q) + 16'h0001)
    else $error("Prescaler did not advance");
  a_up_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    tick && go_up && !center_mode && cnt_q >= arr_m |=> cnt_q == 32'h0000_0000 && upd_evt)
    else $error("Up wrap missing update");
  a_down_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    tick && !go_up && !center_mode && cnt_q == 32'h0000_0000 |=> cnt_q == $past(arr_m) && upd_evt)
    else $error("Down wrap wrong");
  a_freeze_hold: assert property (@(posedge clock) disable iff (!rst_n)
    frozen ##1 frozen |-> $stable(cnt_q) && !upd_evt)
    else $error("Counter moved while frozen");
  a_halt_off: assert property (@(posedge clock) disable iff (!rst_n)
    IS_ADV && dbg_halt ##1 dbg_halt |-> ch_out == 4'h0 && ch_out_n == 3'h0)
    else $error("Outputs active during halt");
  a_small_up: assert property (@(posedge clock) disable iff (!rst_n)
    IS_SMALL && tick && cnt_q < arr_m |=> cnt_q == $past(cnt_q) + 32'h0000_0001)
    else $error("Small timer not counting up");
  a_opm_stop: assert property (@(posedge clock) disable iff (!rst_n)
    st_q == agpt_pkg::ST_RUN && cnt_en && one_pulse && upd_d |=> st_q == agpt_pkg::ST_DONE ##1 !tick)
    else $error("One-pulse did not stop");
  a_width_16: assert property (@(posedge clock) disable iff (!rst_n)
    !HAS_ENC |-> cnt_q[31:16] == 16'h0000)
    else $error("Counter exceeds 16 bits");
  a_trig_start: assert property (@(posedge clock) disable iff (!rst_n)
    st_q == agpt_pkg::ST_WAIT && cnt_en && trig_in |=> st_q == agpt_pkg::ST_RUN)
    else $error("Trigger did not start timer");
endmodule

// file: bench/agpt_pin_src.sv
// Pin source model: the capture signal sources and the encoder.
// Assumes the bench clock; pins change 1 ns after a rising edge.
module agpt_pin_src (
  input wire logic clock,
  output logic [3:0] ch_in,
  output logic enc_a,
  output logic enc_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Idle levels: an encoder at rest holds its phases
  initial begin
    ch_in = 4'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // ==========================================
  // One high pulse; a long len models a slow source
  task automatic pulse(input int ch, input int len);
    @(posedge clock);
    #1 ch_in[ch] = 1'b1;
    repeat (len) @(posedge clock);
    #1 ch_in[ch] = 1'b0;
  endtask
  // One quadrature step every two cycles; fwd makes phase a lead phase b
  task automatic turn(input bit fwd, input int n);
    repeat (n) begin
      repeat (2) @(posedge clock);
      #1;
      if (fwd == (enc_a == enc_b)) enc_a = ~enc_a;
      else enc_b = ~enc_b;
    end
  endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the timer core: advanced, wide and small variants.
// Assumes a 125 MHz clock; inputs change 1 ns after each rising edge.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] L1 = 32'h0000_0001;
  logic clock, rst_n, cnt_en, dir_down, center_mode, one_pulse, encoder_mode;
  logic dbg_halt, dbg_freeze_en, trig_in, enc_a, enc_b, upd_evt, trig_out, counting, dma_req_upd;
  logic [15:0] psc_div;
  logic [31:0] arr, cnt_val, held, cnt_w, cnt_s;
  logic [3:0][31:0] ccr, cap_val;
  logic [3:0][1:0] ch_mode;
  logic [3:0] ch_pol, ch_in, ch_out, cc_evt, dma_req_cc;
  logic [7:0] dead_time;
  logic [1:0] trig_mode;
  logic [2:0] ch_out_n, outn_s;
  logic [15:0] pv [3] = '{16'h0000, 16'h0002, 16'h0000};
  logic [31:0] av [3] = '{32'h0000_0004, 32'h0000_0003, 32'h0001_0003};
  int fails, n_tests, p, h, hn, hs, k;
  // ==========================================
  // Design, pin sources and clock
  agpt_timer agpt_timer_i (.clock, .rst_n, .cnt_en, .dir_down, .center_mode, .one_pulse,
    .encoder_mode, .psc_div, .arr, .ccr, .ch_mode, .ch_pol, .dead_time, .dbg_halt, .dbg_freeze_en,
    .trig_mode, .trig_in, .enc_a, .enc_b, .ch_in, .cnt_val, .upd_evt, .trig_out, .counting,
    .ch_out, .ch_out_n, .cap_val, .cc_evt, .dma_req_upd, .dma_req_cc);
  agpt_pin_src agpt_pin_src_i (.clock, .ch_in, .enc_a, .enc_b);
  // Wide and small variants see the same inputs; only the outputs under test are kept
  if (1'b1) begin : g_wide
    agpt_timer #(.VARIANT(agpt_pkg::VAR_WIDE)) agpt_timer_i (.clock, .rst_n, .cnt_en, .dir_down, .center_mode,
      .one_pulse, .encoder_mode, .psc_div, .arr, .ccr, .ch_mode, .ch_pol, .dead_time, .dbg_halt, .dbg_freeze_en,
      .trig_mode, .trig_in, .enc_a, .enc_b, .ch_in, .cnt_val(cnt_w), .upd_evt(), .trig_out(), .counting(),
      .ch_out(), .ch_out_n(), .cap_val(), .cc_evt(), .dma_req_upd(), .dma_req_cc());
  end
  if (1'b1) begin : g_small
    agpt_timer #(.VARIANT(agpt_pkg::VAR_SMALL)) agpt_timer_i (.clock, .rst_n, .cnt_en, .dir_down, .center_mode,
      .one_pulse, .encoder_mode, .psc_div, .arr, .ccr, .ch_mode, .ch_pol, .dead_time, .dbg_halt, .dbg_freeze_en,
      .trig_mode, .trig_in, .enc_a, .enc_b, .ch_in, .cnt_val(cnt_s), .upd_evt(), .trig_out(), .counting(),
      .ch_out(), .ch_out_n(outn_s), .cap_val(), .cc_evt(), .dma_req_upd(), .dma_req_cc());
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ==========================================
  // Access and compare tasks
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Full reset between tests, so the count starts from zero each time
  task automatic restart();
    rst_n = 1'b0;
    cnt_en = 1'b0;
    step(2);
    rst_n = 1'b1;
    cnt_en = 1'b1;
    step();
  endtask
  // Bounded wait, a hung counter shows up as a mismatch, not a stall
  task automatic wait_upd();
    k = 0;
    while (upd_evt !== 1'b1 && k < 300) begin
      step();
      k++;
    end
    chk("update seen", L1, {31'h0000_0000, upd_evt});
  endtask
  task automatic period();
    wait_upd();
    step();
    chk("update width", '0, {31'h0000_0000, upd_evt});
    p = 1;
    while (upd_evt !== 1'b1 && p < 300) begin
      step();
      p++;
    end
  endtask
  // High cycles of each side of pair 0, and of the small complement, over one 5-cycle period
  task automatic duty();
    h = 0;
    hn = 0;
    hs = 0;
    repeat (5) begin
      step();
      h += (ch_out[0] === 1'b1);
      hn += (ch_out_n[0] === 1'b1);
      hs += (outn_s[0] === 1'b1);
    end
  endtask
  // ==========================================
  // Both sides high would short a bridge leg; pol stays 0 throughout
  always @(posedge clock) begin
    if (rst_n && ch_out[0] && ch_out_n[0]) begin
      fails++;
      $display("Error pair overlap expected 0 seen 1");
    end
  end
  // Watchdog, far above the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test();
  end
  // ==========================================
  // Test sequence
  initial begin
    {rst_n, cnt_en, dir_down, center_mode, one_pulse, encoder_mode} = 6'h00;
    {dbg_halt, dbg_freeze_en, trig_in} = 3'h0;
    {psc_div, arr, ccr, ch_mode, ch_pol, dead_time, trig_mode} = '0;
    step(12);
    for (int i = 0; i < 3; i++) begin
      psc_div = pv[i];
      arr = av[i];
      restart();
      period();
      chk("update period", (psc_div + 1) * ((arr & agpt_pkg::MASK_16) + 1), p);
      chk("count after wrap", '0, cnt_val);
      chk("trigger out", L1, {31'h0000_0000, trig_out});
      chk("update dma", L1, {31'h0000_0000, dma_req_upd});
    end
    $display("done time base");
    psc_div = 16'h0000;
    arr = 32'h0000_0004;
    dir_down = 1'b1;
    restart();
    period();
    chk("down period", 32'h0000_0005, p);
    chk("reload after underflow", arr, cnt_val);
    // Six ticks upward from zero with a reload of 4 leave the small count at 1
    chk("small counts up", L1, cnt_s);
    dir_down = 1'b0;
    center_mode = 1'b1;
    restart();
    period();
    chk("center period", arr, p);
    center_mode = 1'b0;
    $display("done count modes");
    ch_mode[0] = agpt_pkg::CH_PWM;
    for (int c = 0; c <= 5; c += (c == 2) ? 3 : 2) begin
      ccr[0] = c;
      restart();
      wait_upd();
      duty();
      chk("pwm high", c, h);
      chk("pwm complement", 5 - c, hn);
      chk("small complement", 5 - c, hs);
    end
    dead_time = 8'h01;
    ccr[0] = 32'h0000_0002;
    // Channel 2 toggles at each count of 2, once per 5-cycle period
    ch_mode[2] = agpt_pkg::CH_COMPARE;
    ccr[2] = 32'h0000_0002;
    restart();
    wait_upd();
    chk("compare toggled", L1, {31'h0000_0000, ch_out[2]});
    duty();
    chk("compare toggled back", '0, {31'h0000_0000, ch_out[2]});
    chk("dead high", L1, h);
    chk("dead complement", 32'h0000_0002, hn);
    $display("done pwm");
    dead_time = 8'h00;
    ccr[0] = 32'h0000_0005;
    restart();
    step(3);
    dbg_halt = 1'b1;
    step(2);
    chk("forced off", '0, {31'h0000_0000, ch_out[0]});
    chk("halt without freeze", L1, {31'h0000_0000, counting});
    dbg_freeze_en = 1'b1;
    step(2);
    chk("frozen", '0, {31'h0000_0000, counting});
    held = cnt_val;
    step(4);
    chk("held count", held, cnt_val);
    $display("done debug");
    ch_mode[1] = agpt_pkg::CH_CAPTURE;
    agpt_pin_src_i.pulse(1, 2);
    k = 0;
    while (cc_evt[1] !== 1'b1 && k < 8) begin
      step();
      k++;
    end
    chk("capture event", L1, {31'h0000_0000, cc_evt[1]});
    chk("capture dma", L1, {31'h0000_0000, dma_req_cc[1]});
    chk("capture value", held, cap_val[1]);
    {dbg_halt, dbg_freeze_en} = 2'h0;
    ch_mode = '0;
    $display("done capture");
    one_pulse = 1'b1;
    arr = 32'h0000_0003;
    restart();
    wait_upd();
    h = 0;
    repeat (20) begin
      step();
      h += (upd_evt === 1'b1);
    end
    chk("updates after one pulse", '0, h);
    chk("stopped after one pulse", '0, {31'h0000_0000, counting});
    one_pulse = 1'b0;
    $display("done one pulse");
    trig_mode = agpt_pkg::TRG_START;
    restart();
    step(4);
    chk("waits for trigger", '0, {31'h0000_0000, counting});
    trig_in = 1'b1;
    step();
    trig_in = 1'b0;
    step(2);
    chk("started by trigger", L1, {31'h0000_0000, counting});
    trig_mode = agpt_pkg::TRG_CLOCK;
    arr = 32'h0000_0064;
    restart();
    step(3);
    repeat (3) begin
      trig_in = 1'b1;
      step();
      trig_in = 1'b0;
      step();
    end
    step(2);
    chk("trigger ticks", 32'h0000_0003, cnt_val);
    $display("done trigger");
    // Wide variant: phase a leading counts up, the reverse runs through zero to the 32-bit reload
    trig_mode = agpt_pkg::TRG_NONE;
    encoder_mode = 1'b1;
    arr = 32'h0001_0005;
    restart();
    agpt_pin_src_i.turn(1'b1, 4);
    step(4);
    chk("encoder forward", 32'h0000_0004, cnt_w);
    agpt_pin_src_i.turn(1'b0, 6);
    step(4);
    chk("encoder wrap", 32'h0001_0004, cnt_w);
    $display("done encoder");
    end_of_test();
  end
endmodule
